// [src/prot_regs_pkg.sv]
// constants for the protection status and configuration register slice
package prot_regs_pkg;
  // register addresses
  localparam logic [7:0] ADDR_WARN_LIMIT = 8'h20;
  localparam logic [7:0] ADDR_WARN_STAT  = 8'h24;
  localparam logic [7:0] ADDR_CURRENT_MONITOR_PIN       = 8'h26;
  localparam logic [7:0] ADDR_LOCK       = 8'h2A;
  localparam logic [7:0] ADDR_RAMP_STAT  = 8'h2B;
  localparam logic [7:0] ADDR_OC_STAT    = 8'h2D;
  localparam logic [7:0] ADDR_OC_CFG     = 8'h2E;
  localparam logic [7:0] ADDR_SECOND_A   = 8'h46;
  localparam logic [7:0] ADDR_SECOND_B   = 8'h47;

  // reset values
  localparam logic [7:0] RST_WARN_LIMIT = 8'hFF;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // field positions and masks
  localparam int         WARN_BIT       = 0;
  localparam int         LOCK_BIT       = 0;
  localparam int         SECOND_OC_BIT  = 0;
  localparam logic [7:0] RAMP_MASK      = 8'h0F;
  localparam logic [7:0] OC_MASK        = 8'h0F;
  localparam int         OC_LIMIT_HI    = 3;
  localparam int         OC_LIMIT_LO    = 2;
  localparam int         OC_DELAY_HI    = 1;
  localparam int         OC_DELAY_LO    = 0;

  // ramp duration table, microseconds
  localparam logic [13:0] RAMP_STEP_FINE_US = 14'h0096;
  localparam logic [13:0] RAMP_ONE_MS_US    = 14'h03E8;
  localparam logic [3:0]  RAMP_FINE_LAST    = 4'h5;
  localparam logic [3:0]  RAMP_ONE_MS_CODE  = 4'h6;

  // per-phase sense limit, millivolts
  localparam logic [7:0] LIMIT_MV_0 = 8'h41;
  localparam logic [7:0] LIMIT_MV_1 = 8'h4B;
  localparam logic [7:0] LIMIT_MV_2 = 8'h64;
  localparam logic [7:0] LIMIT_MV_3 = 8'h86;

  // latch-off delay, milliseconds
  localparam logic [3:0] DELAY_MS_0 = 4'h4;
  localparam logic [3:0] DELAY_MS_1 = 4'h6;
  localparam logic [3:0] DELAY_MS_2 = 4'h8;
  localparam logic [3:0] DELAY_MS_3 = 4'hA;
endpackage

// [src/protection_status_config_regs.sv]
// protection status and configuration register slice of a buck controller
`timescale 1ns/100ps

// How it works
// - warning bit 0 sets when current reading exceeds the warning limit
// - warning bit is sticky; only an enable toggle or nrst clears it
// - alert output asserts whenever the current exceeds the warning limit
// - readback register holds the 8-bit monitor conversion, 0xFF at 2 V
// - writing 1 to lock bit 0 freezes all lockable limit registers
// - lock is cleared only by power cycle; locked registers ignore writes
// - soft-start strap is sampled when enable rises, setting the ramp rate
// - ramp code sits in bits 3:0, upper bits reserved
// - ramp codes map to 0.15 ms steps to 0.9 ms, then 1 ms to 10 ms
// - overcurrent strap sampled on enable rise, code reported in status
// - strap sampling repeats on every enable rising edge
// - host writes to overcurrent config take effect only with both A, B bits
// - limit and delay fields in config are set independently
// - bits 3:2 pick phase limit 65, 75, 100 or 134 mV
// - bits 1:0 pick latch-off delay 4, 6, 8 or 10 ms
module protection_status_config_regs (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // pins from outside the clock domain
  input  wire logic        enablePin,
  input  wire logic [3:0]  rampStrapCode,
  input  wire logic [3:0]  overcurrentStrapCode,
  // current monitor conversion, same clock
  input  wire logic [7:0]  currentMonitorCode,
  input  wire logic        currentMonitorValid,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  // status and effective settings
  output logic             alert,
  output logic [13:0]      rampDurationUs,
  output logic [7:0]       phaseLimitMv,
  output logic [3:0]       latchOffMs
);

  ////////////////////////////////////////////////////////////////////////////
  // lookup functions

  function automatic logic [13:0] rampUs(input logic [3:0] code);
    logic [13:0] r;
    r = '0;
    if (code <= prot_regs_pkg::RAMP_FINE_LAST) begin
      r = 14'((code + 4'h1) * prot_regs_pkg::RAMP_STEP_FINE_US);
    end else begin
      r = 14'((code - prot_regs_pkg::RAMP_ONE_MS_CODE + 4'h1)
              * prot_regs_pkg::RAMP_ONE_MS_US);
    end
    return r;
  endfunction

  function automatic logic [7:0] limitMv(input logic [1:0] sel);
    logic [7:0] r;
    r = '0;
    unique case (sel)
      2'h0: r = prot_regs_pkg::LIMIT_MV_0;
      2'h1: r = prot_regs_pkg::LIMIT_MV_1;
      2'h2: r = prot_regs_pkg::LIMIT_MV_2;
      2'h3: r = prot_regs_pkg::LIMIT_MV_3;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] delayMs(input logic [1:0] sel);
    logic [3:0] r;
    r = '0;
    unique case (sel)
      2'h0: r = prot_regs_pkg::DELAY_MS_0;
      2'h1: r = prot_regs_pkg::DELAY_MS_1;
      2'h2: r = prot_regs_pkg::DELAY_MS_2;
      2'h3: r = prot_regs_pkg::DELAY_MS_3;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a value counts once stages two and three agree

  logic [2:0] enSync_ff;
  logic [3:0] rampS1_ff;
  logic [3:0] rampS2_ff;
  logic [3:0] rampS3_ff;
  logic [3:0] ocS1_ff;
  logic [3:0] ocS2_ff;
  logic [3:0] ocS3_ff;
  logic       enStable_ff;
  logic [3:0] rampStable_ff;
  logic [3:0] ocStable_ff;
  logic       enRise;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enSync_ff <= '0;
      rampS1_ff <= '0;
      rampS2_ff <= '0;
      rampS3_ff <= '0;
      ocS1_ff   <= '0;
      ocS2_ff   <= '0;
      ocS3_ff   <= '0;
    end else begin
      enSync_ff <= {enSync_ff[1:0], enablePin};
      rampS1_ff <= rampStrapCode;
      rampS2_ff <= rampS1_ff;
      rampS3_ff <= rampS2_ff;
      ocS1_ff   <= overcurrentStrapCode;
      ocS2_ff   <= ocS1_ff;
      ocS3_ff   <= ocS2_ff;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enStable_ff   <= 1'b0;
      rampStable_ff <= '0;
      ocStable_ff   <= '0;
    end else begin
      if (enSync_ff[1] == enSync_ff[2]) begin
        enStable_ff <= enSync_ff[2];
      end
      if (rampS2_ff == rampS3_ff) begin
        rampStable_ff <= rampS3_ff;
      end
      if (ocS2_ff == ocS3_ff) begin
        ocStable_ff <= ocS3_ff;
      end
    end
  end

  // one-cycle pulse on each accepted rising edge of enable
  assign enRise = (enSync_ff[1] == enSync_ff[2]) && enSync_ff[2] && !enStable_ff;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  logic [3:0] rampCode_ff;
  logic [3:0] ocStrap_ff;

  // straps may still be settling while enable is low, so only the edge samples them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rampCode_ff <= '0;
      ocStrap_ff  <= '0;
    end else if (enRise) begin
      rampCode_ff <= rampStable_ff;
      ocStrap_ff  <= ocStable_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers

  logic       wrHit;
  logic       lock_ff;
  logic [7:0] warnLimit_ff;
  logic [3:0] ocCfg_ff;
  logic       secondA_ff;
  logic       secondB_ff;

  assign wrHit = regWr && !lock_ff;

  // lock leaves only with nrst, which is the power-on reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lock_ff <= 1'b0;
    end else if (regWr && regAddr == prot_regs_pkg::ADDR_LOCK
                 && regWrData[prot_regs_pkg::LOCK_BIT]) begin
      lock_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      warnLimit_ff <= prot_regs_pkg::RST_WARN_LIMIT;
    end else if (wrHit && regAddr == prot_regs_pkg::ADDR_WARN_LIMIT) begin
      warnLimit_ff <= regWrData;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ocCfg_ff <= '0;
    end else if (wrHit && regAddr == prot_regs_pkg::ADDR_OC_CFG) begin
      ocCfg_ff <= regWrData[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      secondA_ff <= 1'b0;
      secondB_ff <= 1'b0;
    end else if (wrHit) begin
      if (regAddr == prot_regs_pkg::ADDR_SECOND_A) begin
        secondA_ff <= regWrData[prot_regs_pkg::SECOND_OC_BIT];
      end
      if (regAddr == prot_regs_pkg::ADDR_SECOND_B) begin
        secondB_ff <= regWrData[prot_regs_pkg::SECOND_OC_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current readback and sticky warning

  logic [7:0] current_monitor_pin_ff;
  logic       warn_ff;
  logic       overLimit;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      current_monitor_pin_ff <= '0;
    end else if (currentMonitorValid) begin
      current_monitor_pin_ff <= currentMonitorCode;
    end
  end

  assign overLimit = current_monitor_pin_ff > warnLimit_ff;

  // set beats the enable-edge clear so a coincident event is kept
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      warn_ff <= 1'b0;
    end else if (overLimit) begin
      warn_ff <= 1'b1;
    end else if (enRise) begin
      warn_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      alert <= 1'b0;
    end else begin
      alert <= overLimit || warn_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective settings

  logic       cfgPath;
  logic [3:0] ocEff;

  assign cfgPath = secondA_ff && secondB_ff;
  assign ocEff   = cfgPath ? ocCfg_ff : ocStrap_ff;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rampDurationUs <= '0;
      phaseLimitMv   <= '0;
      latchOffMs     <= '0;
    end else begin
      rampDurationUs <= rampUs(rampCode_ff);
      phaseLimitMv   <= limitMv(ocEff[prot_regs_pkg::OC_LIMIT_HI:
                                      prot_regs_pkg::OC_LIMIT_LO]);
      latchOffMs     <= delayMs(ocEff[prot_regs_pkg::OC_DELAY_HI:
                                      prot_regs_pkg::OC_DELAY_LO]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [7:0] rdMux;

  always_comb begin
    rdMux = prot_regs_pkg::RST_ZERO;
    unique case (regAddr)
      prot_regs_pkg::ADDR_WARN_LIMIT: rdMux = warnLimit_ff;
      prot_regs_pkg::ADDR_WARN_STAT:  rdMux = {7'h00, warn_ff};
      prot_regs_pkg::ADDR_CURRENT_MONITOR_PIN:       rdMux = current_monitor_pin_ff;
      prot_regs_pkg::ADDR_LOCK:       rdMux = {7'h00, lock_ff};
      prot_regs_pkg::ADDR_RAMP_STAT:
        rdMux = {4'h0, rampCode_ff} & prot_regs_pkg::RAMP_MASK;
      prot_regs_pkg::ADDR_OC_STAT:
        rdMux = {4'h0, ocStrap_ff} & prot_regs_pkg::OC_MASK;
      prot_regs_pkg::ADDR_OC_CFG:
        rdMux = {4'h0, ocCfg_ff} & prot_regs_pkg::OC_MASK;
      prot_regs_pkg::ADDR_SECOND_A:   rdMux = {7'h00, secondA_ff};
      prot_regs_pkg::ADDR_SECOND_B:   rdMux = {7'h00, secondB_ff};
      default:                        rdMux = prot_regs_pkg::RST_ZERO;
    endcase
  end

  // reads have no side effect: the warning stays set across them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= rdMux;
    end
  end

endmodule // protection_status_config_regs

// [sim/reg_host_model.sv]
// host-side model that drives the register port
`timescale 1ns/100ps
module reg_host_model (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWr,
  output logic            regRd,
  input  wire logic [7:0] regRdData
);
  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWr     = 1'b0;
    regRd     = 1'b0;
  end

  // idle address and data are inverted so a stale value is never mistaken for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge core_clk);
    regWr     <= 1'b0;
    regAddr   <= ~a;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask
endmodule // reg_host_model

// [sim/prot_regs_monitor.sv]
// concurrent checks on the protection register slice ports
`timescale 1ns/100ps
module prot_regs_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // pins and monitor
  input wire logic        enablePin,
  input wire logic [3:0]  rampStrapCode,
  input wire logic [3:0]  overcurrentStrapCode,
  input wire logic [7:0]  currentMonitorCode,
  input wire logic        currentMonitorValid,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdData,
  // outputs
  input wire logic        alert,
  input wire logic [13:0] rampDurationUs,
  input wire logic [7:0]  phaseLimitMv,
  input wire logic [3:0]  latchOffMs
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // enable history: the sticky warning may only drop shortly after enable rose,
  // so a clear on a read or with enable held high would be caught
  logic [7:0] enHist_ff;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) enHist_ff <= 8'h00;
    else enHist_ff <= {enHist_ff[6:0], enablePin};
  end

  sequence ioutLoad;
    currentMonitorValid ##1 !currentMonitorValid ##1 (regRd && regAddr == 8'h26);
  endsequence

  rdata_hold_a: assert property (!regRd |=> $stable(regRdData))
    else $error("read data changed without a read");
  current_monitor_pin_read_a: assert property (ioutLoad |=> regRdData == $past(currentMonitorCode, 3))
    else $error("current readback differs from loaded code");
  alert_sticky_a: assert property ($fell(alert) |->
    (enHist_ff[6:0] & ~enHist_ff[7:1]) != 7'h00)
    else $error("alert dropped without enable");
  limit_code_a: assert property ($past(nrst) |->
    phaseLimitMv inside {8'h41, 8'h4B, 8'h64, 8'h86}) else $error("phase limit off table");
  delay_code_a: assert property ($past(nrst) |->
    latchOffMs inside {4'h4, 4'h6, 4'h8, 4'hA}) else $error("latch-off delay off table");
  ramp_code_a: assert property ($past(nrst) |->
    (rampDurationUs % 14'h0096 == 14'h0000 && rampDurationUs inside {[14'h0096:14'h0384]})
    || (rampDurationUs % 14'h03E8 == 14'h0000 && rampDurationUs inside {[14'h03E8:14'h2710]}))
    else $error("ramp duration off table");
  resv_bits_a: assert property (regRd && regAddr inside {8'h24, 8'h2A} |=>
    regRdData[7:1] == 7'h00) else $error("reserved high bits not zero");
  resv_nibble_a: assert property (regRd && regAddr inside {8'h2B, 8'h2D, 8'h2E} |=>
    regRdData[7:4] == 4'h0) else $error("reserved nibble not zero");
  unmapped_zero_a: assert property (regRd && regAddr == 8'h25 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
endmodule // prot_regs_monitor

// [sim/protection_status_config_regs_bench.sv]
// self-checking bench for the protection register slice
`timescale 1ns/100ps
module protection_status_config_regs_bench;
  logic        core_clk;
  logic        nrst;
  logic        enablePin;
  logic [3:0]  rampStrapCode;
  logic [3:0]  overcurrentStrapCode;
  logic [7:0]  currentMonitorCode;
  logic        currentMonitorValid;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdData;
  logic        alert;
  logic [13:0] rampDurationUs;
  logic [7:0]  phaseLimitMv;
  logic [3:0]  latchOffMs;
  logic [7:0]  rdVal;
  logic [7:0]  limTab [4] = '{8'h41, 8'h4B, 8'h64, 8'h86};
  int          nFail = 0;
  int          checksDone = 0;

  protection_status_config_regs i_protection_status_config_regs (
    .core_clk             (core_clk),
    .nrst                 (nrst),
    .enablePin            (enablePin),
    .rampStrapCode        (rampStrapCode),
    .overcurrentStrapCode (overcurrentStrapCode),
    .currentMonitorCode   (currentMonitorCode),
    .currentMonitorValid  (currentMonitorValid),
    .regAddr              (regAddr),
    .regWrData            (regWrData),
    .regWr                (regWr),
    .regRd                (regRd),
    .regRdData            (regRdData),
    .alert                (alert),
    .rampDurationUs       (rampDurationUs),
    .phaseLimitMv         (phaseLimitMv),
    .latchOffMs           (latchOffMs)
  );
  reg_host_model i_reg_host_model (
    .core_clk  (core_clk),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regWr     (regWr),
    .regRd     (regRd),
    .regRdData (regRdData)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic printVerdict;
    $display("checks %0d, mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    i_reg_host_model.rd(a, rdVal);
    chk(16'(rdVal), 16'(e));
  endtask

  // straps are already stable well before the rise, as the sync chain needs
  task automatic toggleEn;
    @(posedge core_clk) enablePin <= 1'b0;
    repeat (5) @(posedge core_clk);
    enablePin <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic sample(input logic [7:0] c);
    @(posedge core_clk);
    currentMonitorCode  <= c;
    currentMonitorValid <= 1'b1;
    @(posedge core_clk) currentMonitorValid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic testReset;
    rdChk(8'h20, 8'hFF);
    rdChk(8'h2A, 8'h00);
    rdChk(8'h2E, 8'h00);
    chk(16'(phaseLimitMv), 16'h0041);
    chk(16'(latchOffMs), 16'h0004);
  endtask

  task automatic testStraps;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      rampStrapCode        <= 4'(i);
      overcurrentStrapCode <= 4'(i);
      toggleEn();
      rdChk(8'h2B, 8'(i));
      rdChk(8'h2D, 8'(i));
      chk(16'(rampDurationUs), (i < 6) ? 16'h0096 * 16'(i + 1) : 16'h03E8 * 16'(i - 5));
      chk(16'(phaseLimitMv), 16'(limTab[i / 4]));
      chk(16'(latchOffMs), 16'h0004 + 16'h0002 * 16'(i % 4));
    end
  endtask

  task automatic testWarn;
    i_reg_host_model.wr(8'h20, 8'h80);
    sample(8'h80);
    rdChk(8'h26, 8'h80);
    rdChk(8'h24, 8'h00);
    sample(8'h81);
    rdChk(8'h24, 8'h01);
    chk(16'(alert), 16'h0001);
    sample(8'h10);
    rdChk(8'h24, 8'h01);
    chk(16'(alert), 16'h0001);
    toggleEn();
    rdChk(8'h24, 8'h00);
    chk(16'(alert), 16'h0000);
  endtask

  task automatic testCfg;
    i_reg_host_model.wr(8'h2E, 8'hF6);
    rdChk(8'h2E, 8'h06);
    i_reg_host_model.wr(8'h46, 8'h01);
    repeat (3) @(posedge core_clk);
    chk(16'(phaseLimitMv), 16'h0086);
    i_reg_host_model.wr(8'h47, 8'h01);
    repeat (3) @(posedge core_clk);
    chk(16'(phaseLimitMv), 16'h004B);
    chk(16'(latchOffMs), 16'h0008);
    i_reg_host_model.wr(8'h2E, 8'h09);
    repeat (3) @(posedge core_clk);
    chk(16'(phaseLimitMv), 16'h0064);
    chk(16'(latchOffMs), 16'h0006);
  endtask

  task automatic testLock;
    i_reg_host_model.wr(8'h2A, 8'h01);
    rdChk(8'h2A, 8'h01);
    i_reg_host_model.wr(8'h20, 8'h11);
    i_reg_host_model.wr(8'h2E, 8'h00);
    i_reg_host_model.wr(8'h2A, 8'h00);
    i_reg_host_model.wr(8'h46, 8'h00);
    i_reg_host_model.wr(8'h24, 8'hFF);
    rdChk(8'h20, 8'h80);
    rdChk(8'h2E, 8'h09);
    rdChk(8'h46, 8'h01);
    toggleEn();
    rdChk(8'h2A, 8'h01);
    rdChk(8'h24, 8'h00);
    rdChk(8'h25, 8'h00);
    @(posedge core_clk) nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rdChk(8'h2A, 8'h00);
    rdChk(8'h20, 8'hFF);
  endtask

  initial begin
    nrst                 = 1'b0;
    enablePin            = 1'b0;
    rampStrapCode        = 4'h0;
    overcurrentStrapCode = 4'h0;
    currentMonitorCode   = 8'h00;
    currentMonitorValid  = 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    testReset();
    testStraps();
    testWarn();
    testCfg();
    testLock();
    printVerdict();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    nFail++;
    printVerdict();
  end
endmodule // protection_status_config_regs_bench

bind protection_status_config_regs prot_regs_monitor i_prot_regs_monitor (
  .core_clk             (core_clk),
  .nrst                 (nrst),
  .enablePin            (enablePin),
  .rampStrapCode        (rampStrapCode),
  .overcurrentStrapCode (overcurrentStrapCode),
  .currentMonitorCode   (currentMonitorCode),
  .currentMonitorValid  (currentMonitorValid),
  .regAddr              (regAddr),
  .regWrData            (regWrData),
  .regWr                (regWr),
  .regRd                (regRd),
  .regRdData            (regRdData),
  .alert                (alert),
  .rampDurationUs       (rampDurationUs),
  .phaseLimitMv         (phaseLimitMv),
  .latchOffMs           (latchOffMs)
);
